// >>> hw/strap_pkg.sv
/*
 Package for the reset strap capture and boot select block: boot codes,
 strap field positions, reset values and the small timing counts.
 Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package strap_pkg;

  // Boot source strap codes.
  localparam logic [1:0] BOOT_HOST_PLL_OFF = 2'h0;
  localparam logic [1:0] BOOT_SERIAL = 2'h1;
  localparam logic [1:0] BOOT_HOST_PLL_ON = 2'h2;
  localparam logic [1:0] BOOT_RESERVED = 2'h3;

  // Host word group: four 16-bit words make one 64-bit boot item.
  localparam int unsigned GROUP_WORDS = 4;
  localparam logic [1:0] GROUP_LAST = 2'h3;

  // Hard reset drive time, in clock cycles.
  localparam int unsigned HARD_RESET_N_DRIVE_CYCLES = 16;
  localparam logic [4:0] HARD_RESET_N_DRIVE_COUNT = 5'h10;

  // Reset values.
  localparam logic [1:0] BOOT_SOURCE_RESET = 2'h3;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [2:0] {
    st_por,
    st_hard_reset,
    st_rom,
    st_host_boot,
    st_serial_boot,
    st_run,
    st_idle
  } boot_state_e;

  // Latched configuration handed to the boot loader.
  typedef struct packed {
    logic [1:0] boot_source;
    logic watchdog_enable;
    logic strobe_active_high;
    logic strobe_mode;
    logic width_8bit;
    logic [1:0] host_request_mode;
  } strap_cfg_s;

  // Raw strap pins as one bundle.
  typedef struct packed {
    logic boot_source_strap_hi;
    logic boot_source_strap_lo;
    logic watchdog_enable_strap;
    logic host_strobe_polarity_strap;
    logic host_strobe_mode_strap;
    logic host_width_strap;
    logic [1:0] host_request_pin;
  } strap_pins_s;

  localparam strap_cfg_s CFG_RESET = '{
    boot_source: 2'h3, watchdog_enable: 1'b0, strobe_active_high: 1'b0,
    strobe_mode: 1'b0, width_8bit: 1'b0, host_request_mode: 2'h0};

endpackage : strap_pkg

// >>> hw/strap_sync.sv
/*
 Two flip-flop synchroniser for a bundle of asynchronous pins.
 Assumes the pins are quasi-static or that each bit is read on its own.
*/
`timescale 1ns/10ps
`default_nettype none
module strap_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins in and synchronised out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule : strap_sync
`default_nettype wire

// >>> hw/reset_strap_boot_select.sv
/*
 Reset strap capture and boot path selection. Samples the straps when
 power-on reset deasserts, holds them, and steps through ROM boot to the
 host or serial boot path. Assumes clk is the raw input clock and that the
 board keeps the straps steady until power-on reset releases.
*/
// Summary of operation
// R1: Capture straps on power-on reset release.
// R2: Code 00 host boot, 01 serial boot.
// R3: Code 10 host with PLL, 11 reserved.
// R4: Watchdog strap 0 off, 1 on.
// R5: Strobe strap 0 active low, 1 high.
// R6: Width strap 0 sixteen bits, 1 eight.
// R7: Logic clocked from input clock, PLL bypassed.
// R8: ROM boot first, then core may enable PLL.
// R9: Host boot polled only, no DMA.
// R10: Host sends four words, most significant first.
// R11: Strobe setup from polarity and mode straps.
// R12: Hard reset keeps latched host configuration.
// R13: Host data bit 0 is least significant.
// R14: Serial boot: pins to serial, device master.
// R15: Hard reset pin is open drain, bidirectional.
// R16: Board holds straps until power-on release.
// R17: Host request pins sampled at power-on.
// R18: Latched straps held and exposed to loader.
// R19: Reserved code leaves device idle.
`timescale 1ns/10ps
`default_nettype none
module reset_strap_boot_select (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Reset pins
  input wire logic power_on_reset_n,
  input wire logic hard_reset_in_n,
  output logic hard_reset_out,
  output logic hard_reset_oe_n,
  // Strap pins
  input wire strap_pkg::strap_pins_s strap_pins,
  // Boot loader handshake and software controls
  input wire logic rom_init_done,
  input wire logic pll_enable_req,
  input wire logic soft_hard_reset_req,
  // Host port word stream, polled
  input wire logic host_word_valid,
  input wire logic [15:0] host_word,
  output logic host_word_taken,
  output logic [63:0] boot_item,
  output logic boot_item_valid,
  // Configuration and status out
  output strap_pkg::strap_cfg_s strap_cfg,
  output logic pll_enabled,
  output logic host_boot_active,
  output logic serial_boot_active,
  output logic serial_pins_select,
  output logic serial_master,
  output logic host_dma_enable,
  output logic host_irq_enable,
  output logic boot_idle
);
  import strap_pkg::*;

  typedef struct packed {
    boot_state_e state;
    strap_cfg_s cfg;
    logic por_seen;
    logic [4:0] hr_count;
    logic [1:0] word_idx;
    logic [63:0] item;
    logic item_valid;
    logic taken;
    logic pll_on;
    logic hr_drive;
    // Status copies, so that every status pin except the tied-off DMA and IRQ enables leaves straight from a flop.
    logic host_on;
    logic serial_on;
    logic idle_on;
    logic oe_n;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  strap_pins_s pins_sync;
  logic [1:0] rst_sync;

  // Pins are asynchronous; each passes two flip-flops first.
  strap_sync #(.W($bits(strap_pins_s))) u_strap_sync (
    .clk(clk),
    .rst(rst),
    .din(strap_pins),
    .dout(pins_sync)
  );

  strap_sync #(.W(2)) u_rst_sync (
    .clk(clk),
    .rst(rst),
    .din({power_on_reset_n, hard_reset_in_n}),
    .dout(rst_sync)
  );

  function automatic logic is_host_code(input logic [1:0] code);
    is_host_code = (code == BOOT_HOST_PLL_OFF) || (code == BOOT_HOST_PLL_ON);
  endfunction : is_host_code

  always_comb begin
    s_nxt = s_r;
    s_nxt.item_valid = 1'b0;
    s_nxt.taken = 1'b0;
    if (!rst_sync[1]) begin
      s_nxt.state = st_por;
      s_nxt.por_seen = 1'b1;
      s_nxt.pll_on = 1'b0;
      s_nxt.word_idx = 2'h0;
    end else if (s_r.por_seen) begin
      // R1: capture on release
      s_nxt.por_seen = 1'b0;
      s_nxt.cfg.boot_source = {pins_sync.boot_source_strap_hi,
                               pins_sync.boot_source_strap_lo};
      // R4: watchdog strap
      s_nxt.cfg.watchdog_enable = pins_sync.watchdog_enable_strap;
      // R5: R11: R12: strobe straps only here
      s_nxt.cfg.strobe_active_high = pins_sync.host_strobe_polarity_strap;
      s_nxt.cfg.strobe_mode = pins_sync.host_strobe_mode_strap;
      // R6: width strap
      s_nxt.cfg.width_8bit = pins_sync.host_width_strap;
      // R17: request pins
      s_nxt.cfg.host_request_mode = pins_sync.host_request_pin;
      s_nxt.state = st_rom;
    end else if (!rst_sync[0] || soft_hard_reset_req) begin
      // R12: hard reset keeps cfg
      s_nxt.state = st_hard_reset;
      s_nxt.pll_on = 1'b0;
      s_nxt.word_idx = 2'h0;
      if (soft_hard_reset_req) begin
        s_nxt.hr_drive = 1'b1;
        s_nxt.hr_count = HARD_RESET_N_DRIVE_COUNT;
      end
    end else begin
      case (s_r.state)
        st_por: s_nxt.state = st_rom;
        st_hard_reset: s_nxt.state = st_rom;
        // R8: ROM loader runs first
        st_rom: begin
          if (rom_init_done) begin
            // R2: R3: R19: decode boot code
            if (is_host_code(s_r.cfg.boot_source)) begin
              s_nxt.state = st_host_boot;
            end else if (s_r.cfg.boot_source == BOOT_SERIAL) begin
              s_nxt.state = st_serial_boot;
            end else begin
              s_nxt.state = st_idle;
            end
            // R3: code 10 enables PLL
            s_nxt.pll_on = (s_r.cfg.boot_source == BOOT_HOST_PLL_ON);
          end
        end
        st_host_boot: begin
          // R9: R10: R13: polled word groups
          if (host_word_valid && !s_r.taken) begin
            s_nxt.taken = 1'b1;
            s_nxt.item = {s_r.item[47:0], host_word};
            s_nxt.word_idx = s_r.word_idx + 2'h1;
            s_nxt.item_valid = (s_r.word_idx == GROUP_LAST);
          end
          if (pll_enable_req) begin
            s_nxt.state = st_run;
          end
        end
        st_serial_boot: begin
          if (pll_enable_req) begin
            s_nxt.state = st_run;
          end
        end
        st_run: s_nxt.state = st_run;
        st_idle: s_nxt.state = st_idle;
        default: s_nxt.state = st_idle;
      endcase
      // R8: PLL only after ROM init
      // A hard reset sends the core back through ROM, so the request is refused there too.
      if (pll_enable_req && (s_r.state == st_host_boot || s_r.state == st_serial_boot ||
                             s_r.state == st_run)) begin
        s_nxt.pll_on = 1'b1;
      end
    end
    // R15: open-drain hard reset drive
    if (s_r.hr_drive && !soft_hard_reset_req) begin
      if (s_r.hr_count == 5'h01) begin
        s_nxt.hr_drive = 1'b0;
      end
      s_nxt.hr_count = s_r.hr_count - 5'h01;
    end
    // R14: R19: registered status
    s_nxt.host_on = (s_nxt.state == st_host_boot);
    s_nxt.serial_on = (s_nxt.state == st_serial_boot);
    s_nxt.idle_on = (s_nxt.state == st_idle);
    // R15: enable follows drive
    s_nxt.oe_n = !s_nxt.hr_drive;
  end

  // R7: all logic on the input clock
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '{state: st_por, cfg: CFG_RESET, por_seen: 1'b0, hr_count: 5'h00,
               word_idx: 2'h0, item: 64'h0000000000000000, item_valid: 1'b0,
               taken: 1'b0, pll_on: 1'b0, hr_drive: 1'b0, host_on: 1'b0,
               serial_on: 1'b0, idle_on: 1'b0, oe_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  // R18: held config exposed
  assign strap_cfg = s_r.cfg;
  assign pll_enabled = s_r.pll_on;
  assign host_boot_active = s_r.host_on;
  // R14: serial pins and master role
  assign serial_boot_active = s_r.serial_on;
  assign serial_pins_select = s_r.serial_on;
  assign serial_master = s_r.serial_on;
  assign host_dma_enable = 1'b0;
  assign host_irq_enable = 1'b0;
  assign boot_idle = s_r.idle_on;
  assign host_word_taken = s_r.taken;
  assign boot_item = s_r.item;
  assign boot_item_valid = s_r.item_valid;
  assign hard_reset_out = 1'b0;
  assign hard_reset_oe_n = s_r.oe_n;
endmodule : reset_strap_boot_select
`default_nettype wire

// >>> verification/strap_props.sv
/*
 Port checker for the strap capture and boot select block.
 Assumes it is bound to every instance of that block.
*/
`timescale 1ns/10ps
`default_nettype none
module strap_props (
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic power_on_reset_n,
  // Hard reset pin
  input wire logic hard_reset_out,
  input wire logic hard_reset_oe_n,
  input wire logic soft_hard_reset_req,
  // Host word port
  input wire logic host_word_valid,
  input wire logic host_word_taken,
  input wire logic boot_item_valid,
  // Boot status
  input wire logic pll_enabled,
  input wire logic host_boot_active,
  input wire logic serial_boot_active,
  input wire logic serial_pins_select,
  input wire logic serial_master,
  input wire logic host_dma_enable,
  input wire logic host_irq_enable,
  input wire logic boot_idle,
  input wire strap_pkg::strap_cfg_s strap_cfg
);
  import strap_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] up_r;
  // Capture lands a few cycles after release, so only a settled count is trusted.
  always_ff @(posedge clk) begin
    up_r <= (rst || !power_on_reset_n) ? 3'h0 : up_r + 3'(up_r != 3'h7);
  end
  no_dma_a: assert property (!host_dma_enable && !host_irq_enable)
    else $error("host port dma or irq enabled");
  take_gap_a: assert property (host_word_taken |=> !host_word_taken)
    else $error("host word taken twice in a row");
  take_cause_a: assert property (
    host_word_taken |-> $past(host_word_valid) && $past(host_boot_active))
    else $error("host word taken without request");
  item_word_a: assert property (boot_item_valid |-> host_word_taken)
    else $error("boot item without fourth word");
  cfg_hold_a: assert property (up_r == 3'h7 |-> $stable(strap_cfg))
    else $error("strap configuration changed outside power-on reset");
  host_code_a: assert property (
    $rose(host_boot_active) |->
      !strap_cfg.boot_source[0] && pll_enabled == strap_cfg.boot_source[1])
    else $error("host boot with wrong code or pll state");
  serial_setup_a: assert property (
    serial_boot_active |->
      serial_pins_select && serial_master && strap_cfg.boot_source == BOOT_SERIAL)
    else $error("serial boot setup wrong");
  idle_code_a: assert property (
    boot_idle |->
      strap_cfg.boot_source == BOOT_RESERVED && !host_boot_active && !serial_boot_active)
    else $error("idle state with wrong code or active boot");
  od_drive_a: assert property (
    soft_hard_reset_req |=> (!hard_reset_oe_n && !hard_reset_out) [*8])
    else $error("hard reset not pulled low");
  pll_order_a: assert property (
    $rose(pll_enabled) |->
      host_boot_active || $past(host_boot_active) || $past(serial_boot_active))
    else $error("pll enabled before a boot path was chosen");
  cover property (boot_item_valid);
  cover property (boot_idle);
  cover property (serial_boot_active);
endmodule : strap_props
bind reset_strap_boot_select strap_props u_props (.clk(clk), .rst(rst),
  .power_on_reset_n(power_on_reset_n), .hard_reset_out(hard_reset_out),
  .hard_reset_oe_n(hard_reset_oe_n), .soft_hard_reset_req(soft_hard_reset_req),
  .host_word_valid(host_word_valid), .host_word_taken(host_word_taken),
  .boot_item_valid(boot_item_valid), .pll_enabled(pll_enabled),
  .host_boot_active(host_boot_active), .serial_boot_active(serial_boot_active),
  .serial_pins_select(serial_pins_select), .serial_master(serial_master),
  .host_dma_enable(host_dma_enable), .host_irq_enable(host_irq_enable),
  .boot_idle(boot_idle), .strap_cfg(strap_cfg));
`default_nettype wire

// >>> verification/host_feeder.sv
/*
 External host model that writes boot groups into the host word port.
 Assumes the block's clock and its one-cycle taken pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module host_feeder (
  input wire logic clk,
  input wire logic host_word_taken,
  output logic host_word_valid,
  output logic [15:0] host_word
);
  initial begin
    host_word_valid = 1'b0;
    host_word = 16'h0000;
  end
  task automatic send(input logic [63:0] item, input int gap);
    for (int i = 0; i < 4; i++) begin
      repeat (gap) @(negedge clk);
      @(negedge clk);
      host_word_valid = 1'b1;
      host_word = item[63-16*i -: 16];
      do @(posedge clk); while (host_word_taken !== 1'b1);
      @(negedge clk);
      host_word_valid = 1'b0;
      // Released data is scrambled so a stale word can never pass.
      host_word = ~host_word;
    end
  endtask : send
endmodule : host_feeder
`default_nettype wire

// >>> verification/reset_strap_boot_select_tb_top.sv
/*
 Testbench for the strap capture and boot select block.
 Assumes the design, checker and host model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module reset_strap_boot_select_tb_top;
  import strap_pkg::*;
  logic clk, rst, por_n, hr_ext_n, hr_n, hr_out, hr_oe_n, rom_done, pll_req, hr_req;
  logic valid, taken, item_v, pll_on, host_on, ser_on, ser_sel, ser_m, dma, irq, idle;
  logic [15:0] word;
  logic [63:0] item, last_item;
  strap_pins_s pins;
  strap_cfg_s cfg, exp_cfg;
  int n_fail, comparisons, n_items;
  assign hr_n = hr_ext_n & (hr_oe_n ? 1'b1 : hr_out);
  reset_strap_boot_select DUT (.clk(clk), .rst(rst), .power_on_reset_n(por_n),
    .hard_reset_in_n(hr_n), .hard_reset_out(hr_out), .hard_reset_oe_n(hr_oe_n),
    .strap_pins(pins), .rom_init_done(rom_done), .pll_enable_req(pll_req),
    .soft_hard_reset_req(hr_req), .host_word_valid(valid), .host_word(word),
    .host_word_taken(taken), .boot_item(item), .boot_item_valid(item_v), .strap_cfg(cfg),
    .pll_enabled(pll_on), .host_boot_active(host_on), .serial_boot_active(ser_on),
    .serial_pins_select(ser_sel), .serial_master(ser_m), .host_dma_enable(dma),
    .host_irq_enable(irq), .boot_idle(idle));
  host_feeder host (.clk(clk), .host_word_taken(taken), .host_word_valid(valid),
    .host_word(word));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (item_v === 1'b1) begin
    last_item <= item;
    n_items <= n_items + 1;
  end
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic power_up(input strap_pins_s p);
    por_n = 1'b0;
    pins = p;
    repeat (4) @(negedge clk);
    por_n = 1'b1;
    repeat (6) @(negedge clk);
    exp_cfg = strap_cfg_s'(p);
    `CHK("strap_cfg", exp_cfg, cfg)
  endtask : power_up
  task automatic boot(input logic [1:0] code, input logic [5:0] rest);
    power_up({code, rest});
    pll_req = 1'b1;
    @(negedge clk);
    pll_req = 1'b0;
    rom_done = 1'b1;
    `CHK("pll_in_rom", 1'b0, pll_on)
    @(negedge clk);
    rom_done = 1'b0;
    `CHK("host_boot", ~code[0], host_on)
    `CHK("serial_boot", code == BOOT_SERIAL, ser_on)
    `CHK("pll", code == BOOT_HOST_PLL_ON, pll_on)
    `CHK("idle", code == BOOT_RESERVED, idle)
    `CHK("serial_pins", code == BOOT_SERIAL, ser_sel)
    `CHK("serial_master", code == BOOT_SERIAL, ser_m)
    `CHK("host_dma", 1'b0, dma)
    `CHK("host_irq", 1'b0, irq)
  endtask : boot
  task automatic host_groups;
    boot(BOOT_HOST_PLL_OFF, 6'h3C);
    host.send(64'h0123456789ABCDEF, 0);
    repeat (2) @(negedge clk);
    `CHK("boot_item", 64'h0123456789ABCDEF, last_item)
    host.send(64'hFEDCBA9876543210, 3);
    repeat (2) @(negedge clk);
    `CHK("boot_item", 64'hFEDCBA9876543210, last_item)
    `CHK("item_count", 2, n_items)
    pll_req = 1'b1;
    @(negedge clk);
    pll_req = 1'b0;
    `CHK("pll_after_rom", 1'b1, pll_on)
    `CHK("host_after_pll", 1'b0, host_on)
  endtask : host_groups
  task automatic hard_reset;
    pins = ~pins;
    hr_req = 1'b1;
    @(negedge clk);
    hr_req = 1'b0;
    `CHK("hard_reset_n_oe_n", 1'b0, hr_oe_n)
    `CHK("hard_reset_n_out", 1'b0, hr_out)
    repeat (20) @(negedge clk);
    `CHK("hard_reset_n_oe_n", 1'b1, hr_oe_n)
    hr_ext_n = 1'b0;
    repeat (4) @(negedge clk);
    hr_ext_n = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("strap_cfg", exp_cfg, cfg)
  endtask : hard_reset
  initial begin
    rst = 1'b1;
    por_n = 1'b1;
    hr_ext_n = 1'b1;
    rom_done = 1'b0;
    pll_req = 1'b0;
    hr_req = 1'b0;
    pins = '0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    boot(BOOT_HOST_PLL_OFF, 6'h2A);
    boot(BOOT_SERIAL, 6'h15);
    boot(BOOT_HOST_PLL_ON, 6'h3F);
    boot(BOOT_RESERVED, 6'h00);
    host_groups;
    hard_reset;
    stop_test;
  end
  initial begin
    #200000;
    n_fail++;
    stop_test;
  end
endmodule : reset_strap_boot_select_tb_top
`default_nettype wire
